// File: design/rptc_reset_ctrl.sv
// Purpose: Power-on, hardware and software reset controller with timer
// Assumes: Slow oscillator clock is sampled as a plain input
// Notes:   Reset levels are fixed-length pulses that clear by class
// Notes on behaviour
// R1: Reset pad high means asserted, low means released.
// R2: Pad released before hold threshold gives hardware reset, else power-on.
// R3: Software reset is request bit OR the CPU system reset request.
// R4: With reset-on-wakeup set, waking from deep sleeps raises hardware reset.
// R5: Power-on and hardware resets both start the cold boot sequence.
// R6: Trim, hold timer and RF trim registers clear on power-on only.
// R7: Control and calibration group clears on power-on or hardware reset.
// R8: All other registers clear on any of the three resets; the polarity bit clears on power-on only.
// R9: Hold time setting is seven bits wide, largest value 0x7F.
// R10: Threshold is hold setting times 4096 slow oscillator periods.
// R11: Timer runs on slow clock; hardware forces oscillator on when asserted.
// R12: Pad trigger uses default oscillator trim, GPIO keeps programmed trim.
// R13: GPIO used as power-on source still works as normal pin.
// R14: Pin select holds the GPIO number; zero disables GPIO source.
// R15: Polarity bit zero means active low, one means active high.
// R16: Timer counts while any source asserted, returns to zero on release.
// R17: Overlapping sources keep the timer running without a gap.
// R18: Software reprograms pin select after resets, hold time after power-on.
// R19: Software sets retention trim 0x9 down to 0x4 by temperature.
// R20: Pad and selected GPIO are synchronised before the timer uses them.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "rptc_params.svh"
module rptc_reset_ctrl #(
    parameter int TICK_SCALE = `RPTC_TICK_SCALE
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        resetPad,
    input  wire logic [31:0] gpioPins,
    input  wire logic        slowOscClk,
    input  wire logic        cpuSysResetReq,
    input  wire logic        wakeFromSleep,
    output logic             porResetOut,
    output logic             hwResetOut,
    output logic             swResetOut,
    output logic             coldStartOut,
    output logic             slowOscEnableOut,
    output logic             slowOscDefaultTrimOut,
    output logic [3:0]       retentionTrimOut
);

    localparam logic [4:0] PULSE_CYC = 5'(`RPTC_RESET_PULSE_CYC);

    // Register word match on the byte address
    function automatic logic regHit(input logic [5:0] addr,
                                    input logic [5:0] off);
        regHit = (addr[5:2] == off[5:2]);
    endfunction

    // Registers
    logic                           waitReq_q;
    logic [31:0]                    readData_q;
    logic                           swReqBit_q;
    logic                           resetOnWake_q;
    logic                           oscEnable_q;
    logic [4:0]                     pinSelect_q;
    logic                           polarity_q;
    logic [6:0]                     holdTime_q;
    logic [3:0]                     retTrim_q;
    logic [15:0]                    rfTrim_q;
    logic [31:0]                    coldCfg_q;
    logic [31:0]                    warmCfg_q;
    logic [33:0]                    syncd;
    logic                           slowPrev_q;
    rptc_pkg::rptc_timer_state_type state_q;
    rptc_pkg::rptc_timer_state_type state_d;
    logic [19:0]                    count_q;
    logic [19:0]                    count_d;
    logic                           padSeen_q;
    logic                           padSeen_d;
    rptc_pkg::rptc_cause_type       cause_q;
    logic [4:0]                     pulseCnt_q;
    logic                           porPulse_q;
    logic                           hwPulse_q;
    logic                           swPulse_q;
    logic                           oscEnOut_q;
    logic                           defTrim_q;
    logic                           coldStart_q;

    // Bus decode
    wire        busReq    = avs_read | avs_write;
    wire        accept    = busReq & ~waitReq_q;
    wire        wrTake    = avs_write & accept;
    wire        rdLoad    = avs_read & waitReq_q;
    wire        hitSys    = regHit(avs_address, `RPTC_OFF_SYS_CTRL);
    wire        hitPmu    = regHit(avs_address, `RPTC_OFF_PMU_CTRL);
    wire        hitOsc    = regHit(avs_address, `RPTC_OFF_OSC_CTRL);
    wire        hitPin    = regHit(avs_address, `RPTC_OFF_POR_PIN);
    wire        hitTmr    = regHit(avs_address, `RPTC_OFF_POR_TIMER);
    wire        hitBg     = regHit(avs_address, `RPTC_OFF_BANDGAP);
    wire        hitRf     = regHit(avs_address, `RPTC_OFF_RF_TRIM);
    wire        hitCold   = regHit(avs_address, `RPTC_OFF_COLD_CFG);
    wire        hitWarm   = regHit(avs_address, `RPTC_OFF_WARM_CFG);
    wire        hitStat   = regHit(avs_address, `RPTC_OFF_STATUS);

    // Reset classes seen by this register file
    wire        clrPor    = porPulse_q;
    wire        clrCold   = porPulse_q | hwPulse_q;
    wire        clrAll    = porPulse_q | hwPulse_q | swPulse_q;
    wire        pulseBusy = |pulseCnt_q;

    // Select after the sync flops, so no mux glitch is ever sampled
    // R13: observe only
    // No drive back onto the GPIO, so the pin keeps its normal use.
    wire [31:0] gpioSync  = syncd[32:1];
    wire        padS      = syncd[0];
    wire        gpioS     = gpioSync[pinSelect_q];
    wire        slowS     = syncd[33];
    wire        slowTick  = slowS & ~slowPrev_q;
    // R1: pad level
    wire        padAct    = padS;
    // R14: zero disables
    wire        gpioEn    = (pinSelect_q != 5'h00);
    // R15: polarity select
    wire        gpioAct   = gpioEn & (gpioS == polarity_q);
    wire        anySrc    = padAct | gpioAct;
    // R9: seven-bit hold
    // R10: threshold scale
    wire [19:0] threshold = 20'(holdTime_q) * 20'(TICK_SCALE);

    // Requests into the pulse generator
    wire        porReq    = (state_q == rptc_pkg::RPTC_COUNT) & anySrc &
                            (count_q >= threshold);
    wire        hwPadReq  = (state_q == rptc_pkg::RPTC_COUNT) & ~anySrc &
                            padSeen_q;
    // R4: wake reset
    wire        hwWakeReq = wakeFromSleep & resetOnWake_q;
    // R3: software OR
    wire        swReq     = swReqBit_q | cpuSysResetReq;

    // R20: synchronise pad, all GPIO pins and slow clock
    rptc_sync #(
        .WIDTH   (34)
    ) uSync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn ({slowOscClk, gpioPins, resetPad}),
        .syncOut (syncd)
    );

    // Hold timer next state
    always_comb
    begin
        state_d   = state_q;
        count_d   = count_q;
        padSeen_d = padSeen_q;
        case (state_q)
            rptc_pkg::RPTC_IDLE:
            begin
                count_d   = 20'h00000;
                padSeen_d = padAct;
                if (anySrc)
                    state_d = rptc_pkg::RPTC_COUNT;
            end
            rptc_pkg::RPTC_COUNT:
            begin
                padSeen_d = padSeen_q | padAct;
                // R16: back to zero on release
                if (!anySrc)
                begin
                    state_d = rptc_pkg::RPTC_IDLE;
                    count_d = 20'h00000;
                end
                // R2: long hold is power-on
                else if (count_q >= threshold)
                    state_d = rptc_pkg::RPTC_HELD;
                // R17: overlap keeps counting
                // R11: counts slow clock
                else if (slowTick)
                    count_d = count_q + 20'h00001;
            end
            rptc_pkg::RPTC_HELD:
            begin
                // One power-on per assertion; wait for full release
                if (!anySrc)
                begin
                    state_d = rptc_pkg::RPTC_IDLE;
                    count_d = 20'h00000;
                end
            end
            default:
            begin
                state_d = rptc_pkg::RPTC_IDLE;
                count_d = 20'h00000;
            end
        endcase
    end

    // Timer state and slow clock edge memory
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= rptc_pkg::RPTC_IDLE;
            count_q    <= 20'h00000;
            padSeen_q  <= 1'b0;
            slowPrev_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            count_q    <= count_d;
            padSeen_q  <= padSeen_d;
            slowPrev_q <= slowS;
        end
    end

    // Reset pulse generator; power-on beats hardware beats software
    // Hardware and software requests during a running pulse are dropped,
    // a hardware request during a software pulse too; a power-on never waits.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pulseCnt_q <= 5'h00;
            porPulse_q <= 1'b0;
            hwPulse_q  <= 1'b0;
            swPulse_q  <= 1'b0;
            coldStart_q <= 1'b0;
            cause_q    <= rptc_pkg::RPTC_CAUSE_NONE;
        end
        else if (porReq && !porPulse_q)
        begin
            pulseCnt_q <= PULSE_CYC;
            porPulse_q <= 1'b1;
            hwPulse_q  <= 1'b0;
            swPulse_q  <= 1'b0;
            coldStart_q <= 1'b1;
            cause_q    <= rptc_pkg::RPTC_CAUSE_POR;
        end
        // R2: short hold is hardware
        else if ((hwPadReq || hwWakeReq) && !pulseBusy)
        begin
            pulseCnt_q <= PULSE_CYC;
            hwPulse_q  <= 1'b1;
            coldStart_q <= 1'b1;
            cause_q    <= rptc_pkg::RPTC_CAUSE_HW;
        end
        else if (swReq && !pulseBusy)
        begin
            pulseCnt_q <= PULSE_CYC;
            swPulse_q  <= 1'b1;
            cause_q    <= rptc_pkg::RPTC_CAUSE_SW;
        end
        else if (pulseBusy)
        begin
            pulseCnt_q <= pulseCnt_q - 5'h01;
            if (pulseCnt_q == 5'h01)
            begin
                porPulse_q <= 1'b0;
                hwPulse_q  <= 1'b0;
                swPulse_q  <= 1'b0;
                coldStart_q <= 1'b0;
            end
        end
    end

    // Registers cleared by power-on only
    // R6: power-on only class
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            holdTime_q <= `RPTC_HOLD_RST;
            retTrim_q  <= `RPTC_RET_TRIM_RST;
            rfTrim_q   <= `RPTC_RF_TRIM_RST;
            polarity_q <= `RPTC_POLARITY_RST;
        end
        else if (clrPor)
        begin
            holdTime_q <= `RPTC_HOLD_RST;
            retTrim_q  <= `RPTC_RET_TRIM_RST;
            rfTrim_q   <= `RPTC_RF_TRIM_RST;
            polarity_q <= `RPTC_POLARITY_RST;
        end
        else if (wrTake)
        begin
            if (hitTmr)
                holdTime_q <= avs_writedata[`RPTC_HOLD_MSB:0];
            // Trim code chosen by software per temperature range
            if (hitBg)
                retTrim_q <= avs_writedata[`RPTC_RET_TRIM_MSB:0];
            if (hitRf)
                rfTrim_q <= avs_writedata[15:0];
            if (hitPin)
                polarity_q <= avs_writedata[`RPTC_BIT_POLARITY];
        end
    end

    // Registers cleared by power-on or hardware reset
    // R7: cold class
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resetOnWake_q <= 1'b0;
            oscEnable_q   <= `RPTC_OSC_EN_RST;
            coldCfg_q     <= `RPTC_CFG_RST;
        end
        else if (clrCold)
        begin
            resetOnWake_q <= 1'b0;
            oscEnable_q   <= `RPTC_OSC_EN_RST;
            coldCfg_q     <= `RPTC_CFG_RST;
        end
        else if (wrTake)
        begin
            if (hitPmu)
                resetOnWake_q <= avs_writedata[`RPTC_BIT_RST_ON_WAKE];
            if (hitOsc)
                oscEnable_q <= avs_writedata[`RPTC_BIT_OSC_EN];
            if (hitCold)
                coldCfg_q <= avs_writedata;
        end
    end

    // Registers cleared by any reset; request bit is a one-shot
    // R8: any reset class
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinSelect_q <= `RPTC_PIN_SEL_RST;
            warmCfg_q   <= `RPTC_CFG_RST;
            swReqBit_q  <= 1'b0;
        end
        else if (clrAll)
        begin
            pinSelect_q <= `RPTC_PIN_SEL_RST;
            warmCfg_q   <= `RPTC_CFG_RST;
            swReqBit_q  <= 1'b0;
        end
        else
        begin
            swReqBit_q <= wrTake & hitSys &
                          avs_writedata[`RPTC_BIT_SOFTWARE_RESET_REQUEST];
            if (wrTake && hitPin)
                pinSelect_q <= avs_writedata[`RPTC_PIN_SEL_MSB:0];
            if (wrTake && hitWarm)
                warmCfg_q <= avs_writedata;
        end
    end

    // Read mux; unmapped words read zero
    wire [31:0] rdMux =
        hitPmu  ? {31'h00000000, resetOnWake_q} :
        hitOsc  ? {31'h00000000, oscEnable_q} :
        hitPin  ? {23'h000000, polarity_q, 3'h0, pinSelect_q} :
        hitTmr  ? {25'h0000000, holdTime_q} :
        hitBg   ? {28'h0000000, retTrim_q} :
        hitRf   ? {16'h0000, rfTrim_q} :
        hitCold ? coldCfg_q :
        hitWarm ? warmCfg_q :
        hitStat ? {count_q, 6'h00, gpioAct, padAct, state_q, cause_q} :
        32'h00000000;

    // Bus handshake: one wait state, then a single-cycle accept
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitReq_q  <= 1'b1;
            readData_q <= 32'h00000000;
        end
        else
        begin
            waitReq_q <= ~(busReq & waitReq_q);
            if (rdLoad)
                readData_q <= rdMux;
        end
    end

    // Oscillator control flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oscEnOut_q <= `RPTC_OSC_EN_RST;
            defTrim_q  <= 1'b0;
        end
        else
        begin
            // R11: forced on
            oscEnOut_q <= oscEnable_q | anySrc;
            // R12: pad means default trim
            defTrim_q  <= padAct;
        end
    end

    assign avs_waitrequest       = waitReq_q;
    assign avs_readdata          = readData_q;
    assign porResetOut           = porPulse_q;
    assign hwResetOut            = hwPulse_q;
    assign swResetOut            = swPulse_q;
    // R5: cold boot on both
    assign coldStartOut          = coldStart_q;
    assign slowOscEnableOut      = oscEnOut_q;
    assign slowOscDefaultTrimOut = defTrim_q;
    assign retentionTrimOut      = retTrim_q;

endmodule

// File: design/rptc_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM slave, word-aligned byte addresses
// Notes:   Included by its bare name; definitions only
`ifndef RPTC_PARAMS_SVH
`define RPTC_PARAMS_SVH

// Register byte offsets
`define RPTC_OFF_SYS_CTRL      6'h00
`define RPTC_OFF_PMU_CTRL      6'h04
`define RPTC_OFF_OSC_CTRL      6'h08
`define RPTC_OFF_POR_PIN       6'h0C
`define RPTC_OFF_POR_TIMER     6'h10
`define RPTC_OFF_BANDGAP       6'h14
`define RPTC_OFF_RF_TRIM       6'h18
`define RPTC_OFF_COLD_CFG      6'h1C
`define RPTC_OFF_WARM_CFG      6'h20
`define RPTC_OFF_STATUS        6'h24

// Field positions
`define RPTC_BIT_SOFTWARE_RESET_REQUEST      0
`define RPTC_BIT_RST_ON_WAKE   0
`define RPTC_BIT_OSC_EN        0
`define RPTC_PIN_SEL_MSB       4
`define RPTC_BIT_POLARITY      8
`define RPTC_HOLD_MSB          6
`define RPTC_RET_TRIM_MSB      3

// Reset values
`define RPTC_HOLD_RST          7'h18
`define RPTC_RET_TRIM_RST      4'h9
`define RPTC_OSC_EN_RST        1'h1
`define RPTC_PIN_SEL_RST       5'h00
`define RPTC_POLARITY_RST      1'h0
`define RPTC_RF_TRIM_RST       16'h0000
`define RPTC_CFG_RST           32'h00000000

// Timing: slow ticks per hold unit, internal reset pulse length in ns
`define RPTC_TICK_SCALE        4096
`define RPTC_CLK_PERIOD_NS     100
`define RPTC_RESET_PULSE_NS    1600
`define RPTC_RESET_PULSE_CYC   ((`RPTC_RESET_PULSE_NS + `RPTC_CLK_PERIOD_NS - 1) / `RPTC_CLK_PERIOD_NS)

`endif

// File: design/rptc_pkg.sv
// Purpose: Types shared by the reset controller
// Assumes: Constants live in rptc_params.svh
// Notes:   Used as rptc_pkg::name, never imported
package rptc_pkg;

    typedef enum logic [1:0] {
        RPTC_IDLE  = 2'b00,
        RPTC_COUNT = 2'b01,
        RPTC_HELD  = 2'b10
    } rptc_timer_state_type;

    typedef enum logic [1:0] {
        RPTC_CAUSE_NONE = 2'b00,
        RPTC_CAUSE_POR  = 2'b01,
        RPTC_CAUSE_HW   = 2'b10,
        RPTC_CAUSE_SW   = 2'b11
    } rptc_cause_type;

endpackage

// File: design/rptc_sync.sv
// Purpose: Two-flop synchroniser for a group of unrelated levels
// Assumes: Each bit is an independent level, no bus coherence
// Notes:   First stage feeds the second stage only
`timescale 1ns/1ps
module rptc_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    // One synchroniser pair per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : gSync
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    stage1_q[i] <= 1'b0;
                    syncOut[i]  <= 1'b0;
                end
                else
                begin
                    stage1_q[i] <= asyncIn[i];
                    syncOut[i]  <= stage1_q[i];
                end
            end
        end
    endgenerate

endmodule

// File: test/rptc_reset_ctrl_properties.sv
// Purpose: Port-level timing checks for the reset controller
// Assumes: Pulses last 16 cycles, pad passes two sync flops
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module rptc_reset_ctrl_properties (
    input logic clk,
    input logic rst_n,
    input logic resetPad,
    input logic cpuSysResetReq,
    input logic wakeFromSleep,
    input logic porResetOut,
    input logic hwResetOut,
    input logic swResetOut,
    input logic coldStartOut,
    input logic slowOscEnableOut,
    input logic slowOscDefaultTrimOut
);
    // Any level running
    wire logic anyPulse = porResetOut | hwResetOut | swResetOut;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_por_len: assert property ($rose(porResetOut) |->
        porResetOut[*8] ##1 porResetOut[*8] ##1 !porResetOut)
        else $error("power-on pulse length wrong");
    // Power-on may cut the hardware and software levels short
    chk_hw_len: assert property (
        disable iff (!rst_n || porResetOut)
        $rose(hwResetOut) |->
        hwResetOut[*8] ##1 hwResetOut[*8] ##1 !hwResetOut)
        else $error("hardware pulse length wrong");
    chk_sw_len: assert property (
        disable iff (!rst_n || porResetOut)
        $rose(swResetOut) |->
        swResetOut[*8] ##1 swResetOut[*8] ##1 !swResetOut)
        else $error("software pulse length wrong");
    chk_cold_start_or: assert property (
        coldStartOut == (porResetOut | hwResetOut))
        else $error("cold start mismatch");
    chk_cpu_sw_req: assert property (
        $rose(cpuSysResetReq) && !anyPulse |=> swResetOut)
        else $error("cpu request ignored");
    chk_osc_forced: assert property (
        resetPad [*5] |-> slowOscEnableOut)
        else $error("slow oscillator off while pad held");
    chk_trim_pad: assert property (
        resetPad [*5] |-> slowOscDefaultTrimOut)
        else $error("default trim missing while pad held");
    chk_trim_kept: assert property (
        !resetPad [*5] |-> !slowOscDefaultTrimOut)
        else $error("default trim without pad");
    chk_pad_no_hw: assert property (
        resetPad [*5] ##0 !$past(wakeFromSleep) |-> !$rose(hwResetOut))
        else $error("hardware reset while pad still held");

    cover property ($rose(porResetOut));
    cover property ($rose(hwResetOut));
    cover property ($rose(swResetOut));
endmodule

bind rptc_reset_ctrl rptc_reset_ctrl_properties u_props (
    .clk, .rst_n, .resetPad, .cpuSysResetReq, .wakeFromSleep,
    .porResetOut, .hwResetOut, .swResetOut, .coldStartOut,
    .slowOscEnableOut, .slowOscDefaultTrimOut
);

// File: test/rptc_pad_model.sv
// Purpose: Reset pad driver and GPIO reset source
// Assumes: Pad has a pull-down, selected pin level is commanded
// Notes:   Unselected pins toggle every cycle
`timescale 1ns/1ps
module rptc_pad_model (
    input  logic             clk,
    input  logic             padOn,
    input  logic             gpioOn,
    input  logic             gpioHigh,
    input  logic [4:0]       gpioSel,
    output logic             resetPad,
    output logic      [31:0] gpioPins
);
    logic [31:0] noiseQ = 32'h0;

    // Idle pins toggle to expose decode slips
    always @(posedge clk)
        noiseQ <= ~noiseQ;

    assign resetPad = padOn;

    always_comb
    begin
        gpioPins = noiseQ;
        gpioPins[gpioSel] = gpioHigh ? gpioOn : !gpioOn;
    end
endmodule

// File: test/tb_reset_and_por_timer_control.sv
// Purpose: Self-checking bench for the reset controller
// Assumes: TICK_SCALE 2, slow clock of 8 cycles
// Notes:   Pad and GPIO come from rptc_pad_model
`timescale 1ns/1ps
`include "rptc_params.svh"
`define CHK(g, e) \
    begin \
        checkCount++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("BAD %0t got %0h exp %0h", $time, g, e); \
        end \
    end
module tb_reset_and_por_timer_control;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rdq;
    logic        avs_waitrequest;
    logic        resetPad;
    logic [31:0] gpioPins;
    logic        slowOscClk = 1'b0;
    logic        cpuSysResetReq = 1'b0;
    logic        wakeFromSleep = 1'b0;
    logic        porResetOut, hwResetOut, swResetOut, coldStartOut;
    logic        slowOscEnableOut, slowOscDefaultTrimOut;
    logic [3:0]  retentionTrimOut;
    logic        padOn = 1'b0, gpioOn = 1'b0, gpioHigh = 1'b1;
    logic [4:0]  gpioSel = 5'h05;
    int          fails = 0;
    int          checkCount = 0;
    int          n;
    wire logic [2:0] lvl = {porResetOut, hwResetOut, swResetOut};

    always #50 clk = ~clk;
    // Slow tick every 8 cycles keeps hold counts short
    always
    begin
        repeat (4) @(posedge clk);
        slowOscClk <= ~slowOscClk;
    end

    rptc_reset_ctrl #(.TICK_SCALE(2)) u_dut (
        .clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .resetPad,
        .gpioPins, .slowOscClk, .cpuSysResetReq, .wakeFromSleep,
        .porResetOut, .hwResetOut, .swResetOut, .coldStartOut,
        .slowOscEnableOut, .slowOscDefaultTrimOut, .retentionTrimOut
    );
    rptc_pad_model u_pad (
        .clk, .padOn, .gpioOn, .gpioHigh, .gpioSel, .resetPad, .gpioPins
    );

    task automatic test_done;
        if (fails == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Request held until waitrequest low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        rdq = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            fails++;
            test_done;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdq, e)
    endtask
    // Wait for a level, or prove none comes
    task automatic expectRst(input logic [2:0] e, input int lim);
        n = 0;
        while (lvl === 3'h0 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(lvl, e)
        `CHK(coldStartOut, e[2] | e[1])
        if (n >= lim && e !== 3'h0)
            test_done;
        if (lvl !== 3'h0)
            repeat (20) @(posedge clk);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Power-up values and field width
        rdChk(`RPTC_OFF_POR_TIMER, 32'h18);
        rdChk(`RPTC_OFF_BANDGAP, 32'h9);
        rdChk(`RPTC_OFF_OSC_CTRL, 32'h1);
        rdChk(`RPTC_OFF_POR_PIN, 32'h0);
        rdChk(6'h28, 32'h0);
        wr(`RPTC_OFF_POR_TIMER, 32'hFF);
        rdChk(`RPTC_OFF_POR_TIMER, 32'h7F);
        wr(`RPTC_OFF_BANDGAP, 32'h4);
        rdChk(`RPTC_OFF_BANDGAP, 32'h4);
        `CHK(retentionTrimOut, 4'h4)
        // Software level keeps stronger classes
        wr(`RPTC_OFF_COLD_CFG, 32'hA5A55A5A);
        wr(`RPTC_OFF_WARM_CFG, 32'h12345678);
        wr(`RPTC_OFF_RF_TRIM, 32'hBEEF);
        wr(`RPTC_OFF_POR_TIMER, 32'h2);
        wr(`RPTC_OFF_POR_PIN, 32'h105);
        wr(`RPTC_OFF_SYS_CTRL, 32'h1);
        expectRst(3'h1, 10);
        rdChk(`RPTC_OFF_WARM_CFG, 32'h0);
        rdChk(`RPTC_OFF_COLD_CFG, 32'hA5A55A5A);
        rdChk(`RPTC_OFF_RF_TRIM, 32'hBEEF);
        rdChk(`RPTC_OFF_POR_TIMER, 32'h2);
        rdChk(`RPTC_OFF_POR_PIN, 32'h100);
        rdChk(`RPTC_OFF_SYS_CTRL, 32'h0);
        rdChk(`RPTC_OFF_STATUS, 32'h3);
        cpuSysResetReq <= 1'b1;
        @(posedge clk);
        cpuSysResetReq <= 1'b0;
        expectRst(3'h1, 10);
        // Short pad press gives hardware level
        padOn <= 1'b1;
        repeat (12) @(posedge clk);
        `CHK(slowOscDefaultTrimOut, 1'h1)
        padOn <= 1'b0;
        expectRst(3'h2, 20);
        rdChk(`RPTC_OFF_COLD_CFG, 32'h0);
        rdChk(`RPTC_OFF_POR_TIMER, 32'h2);
        rdChk(`RPTC_OFF_RF_TRIM, 32'hBEEF);
        // Wake with enable, then with it cleared
        wr(`RPTC_OFF_PMU_CTRL, 32'h1);
        for (int i = 1; i >= 0; i--)
        begin
            wakeFromSleep <= 1'b1;
            @(posedge clk);
            wakeFromSleep <= 1'b0;
            expectRst({1'h0, i[0], 1'h0}, 20);
        end
        // Oscillator off, GPIO power-on source
        wr(`RPTC_OFF_OSC_CTRL, 32'h0);
        rdChk(`RPTC_OFF_OSC_CTRL, 32'h0);
        `CHK(slowOscEnableOut, 1'h0)
        wr(`RPTC_OFF_POR_PIN, 32'h105);
        gpioOn <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(slowOscEnableOut, 1'h1)
        `CHK(slowOscDefaultTrimOut, 1'h0)
        expectRst(3'h4, 60);
        `CHK(n >= 18 && n <= 40, 1'b1)
        gpioOn <= 1'b0;
        rdChk(`RPTC_OFF_POR_TIMER, 32'h18);
        rdChk(`RPTC_OFF_BANDGAP, 32'h9);
        rdChk(`RPTC_OFF_RF_TRIM, 32'h0);
        rdChk(`RPTC_OFF_OSC_CTRL, 32'h1);
        `CHK(retentionTrimOut, 4'h9)
        // Active-low pin, pin zero disabled
        gpioHigh <= 1'b0;
        wr(`RPTC_OFF_POR_TIMER, 32'h1);
        wr(`RPTC_OFF_POR_PIN, 32'h005);
        gpioOn <= 1'b1;
        expectRst(3'h4, 60);
        gpioOn <= 1'b0;
        gpioSel <= 5'h00;
        gpioHigh <= 1'b1;
        wr(`RPTC_OFF_POR_TIMER, 32'h1);
        wr(`RPTC_OFF_POR_PIN, 32'h100);
        gpioOn <= 1'b1;
        expectRst(3'h0, 60);
        // Release restarts timer, overlap keeps counting
        gpioOn <= 1'b0;
        gpioSel <= 5'h05;
        wr(`RPTC_OFF_POR_TIMER, 32'h4);
        wr(`RPTC_OFF_POR_PIN, 32'h105);
        gpioOn <= 1'b1;
        repeat (40) @(posedge clk);
        gpioOn <= 1'b0;
        repeat (8) @(posedge clk);
        gpioOn <= 1'b1;
        expectRst(3'h0, 40);
        gpioOn <= 1'b0;
        repeat (8) @(posedge clk);
        padOn <= 1'b1;
        repeat (30) @(posedge clk);
        gpioOn <= 1'b1;
        repeat (10) @(posedge clk);
        padOn <= 1'b0;
        expectRst(3'h4, 60);
        `CHK(n < 40, 1'b1)
        gpioOn <= 1'b0;
        test_done;
    end
endmodule
